// file: rtl/bsc_pkg.sv
// Package: register map, field layout and constants of the bus configuration block
package bsc_pkg;

  localparam logic [11:0] OFS_CONFIG = 12'h000;
  localparam logic [11:0] OFS_AUTOVEC = 12'h004;
  localparam logic [11:0] OFS_RESET_CAUSE = 12'h008;

  localparam logic [31:0] CONFIG_RESET = 32'h00007CFF;
  localparam logic [31:0] CONFIG_WMASK = 32'h00007FFF;
  localparam logic [7:0]  AUTOVEC_RESET = 8'h00;
  localparam logic [7:0]  CAUSE_POWERUP = 8'hC0;
  localparam logic [7:0]  CAUSE_WMASK = 8'hF7;

  localparam int SHOW_LSB = 8;
  localparam int PRIV_BIT = 7;
  localparam int MASK_LSB = 4;
  localparam int IARB_LSB = 0;

  localparam int RC_HARD = 7;
  localparam int RC_POW = 6;
  localparam int RC_WDOG = 5;
  localparam int RC_DBF = 4;
  localparam int RC_LOC = 2;
  localparam int RC_SOFT = 1;

  localparam logic [3:0] FC_SUP_DATA = 4'h5;
  localparam logic [3:0] IARB_RESET = 4'hF;
  localparam logic [3:0] CPM_ARB_LEVEL = 4'h8;
  localparam logic [2:0] LVL_SERIAL_DMA = 3'h4;
  localparam logic [2:0] LVL_GDMA_X = 3'h2;
  localparam logic [2:0] LVL_GDMA_Y = 3'h0;
  localparam logic [2:0] LVL_REFRESH = 3'h6;

  typedef enum logic [1:0] {
    SHOW_OFF = 2'b00,
    SHOW_NOARB = 2'b01,
    SHOW_ARB = 2'b10,
    SHOW_ARB2 = 2'b11
  } show_mode_e;

  typedef struct packed {
    logic       drive_addr;
    logic       drive_data;
    logic       addr_strobe;
    logic       data_strobe;
    logic       data_transfer_ack;
  } ext_bus_s;

  typedef struct packed {
    logic [4:0] cause;
    logic       done;
  } reset_event_s;

endpackage : bsc_pkg

// file: rtl/bus_show_cycle_reset_status_cfg.sv
// Show-cycle, bus-clear, interrupt arbitration and reset cause configuration block
//
// Behaviour
// R1: Mode 00 split buses, arbitration on
// R2: Mode 01 shows cycles, never grants bus
// R3: Mode 1x shows cycles, halts while granting
// R4: Show cycle drives all but address strobe
// R5: No show cycles, no internal data outward
// R6: Ignore bus request while arbitration off
// R7: Request in 1x stops internal master
// R8: Outside masters stay idle in mode 01
// R9: Fast termination never drives transfer ack
// R10: Slave mode reads selector as 00
// R11: Free bus reflects internal address, code
// R12: Protected registers need supervisor data code
// R13: Service level above mask drives bus clear
// R14: Bus clear in releases lower internal masters
// R15: Fixed internal master arbitration levels
// R16: Interrupt priority resets to F
// R17: Communication processor priority is eight
// R18: Enabled level raises autovector acknowledge
// R19: Autovectors need nonzero arbitration priority
// R20: Cause record set at reset completion
// R21: Writing one clears a cause flag
// R22: Separate flags per reset source
// R23: Soft reset flag invalid in slave mode
//
// Decided for this implementation: the APB register port and the register offsets.
`timescale 1ns/1ns
`default_nettype none
module bus_show_cycle_reset_status_cfg
  import bsc_pkg::*;
(
  input  wire logic        pclk,
  input  wire logic        presetn,
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [11:0] paddr,
  input  wire logic [31:0] pwdata,
  input  wire logic [3:0]  function_code,
  output logic             pready,
  output logic [31:0]      prdata,
  output logic             pslverr,
  input  wire logic        slave_mode,
  input  wire logic        internal_access,
  input  wire logic        fast_termination,
  input  wire logic        ext_bus_free,
  input  wire logic        bus_request,
  input  wire logic        bus_grant_acknowledge,
  output logic             bus_grant,
  output logic             internal_halt,
  output logic             ext_arb_enable,
  output ext_bus_s         ext_bus,
  output logic             reflect_addr_fc,
  input  wire logic [2:0]  irq_service_level,
  output logic             bus_clear_out,
  input  wire logic        bus_clear_in,
  input  wire logic [3:0]  master_request,
  output logic [3:0]       master_release,
  input  wire logic        irq_ack_cycle,
  input  wire logic [2:0]  irq_ack_level,
  input  wire logic [3:0]  irq_source_level,
  output logic             irq_arb_win,
  output logic             autovector_ack,
  input  wire logic        reset_done,
  input  wire logic        hard_reset_pin,
  input  wire logic        watchdog_reset,
  input  wire logic        double_fault_reset,
  input  wire logic        clock_loss_reset,
  input  wire logic        clock_loss_reset_enable,
  input  wire logic        vco_running,
  input  wire logic        soft_reset
);

  logic [31:0] module_configuration_q;
  logic [7:0]  autovector_enable_q;
  logic [7:0]  reset_cause_record_q;
  logic        bus_grant_q;
  logic        halt_q;

  function automatic logic [2:0] master_level(input logic [1:0] idx);
    unique case (idx)
      2'd0: master_level = LVL_SERIAL_DMA;
      2'd1: master_level = LVL_GDMA_X;
      2'd2: master_level = LVL_GDMA_Y;
      2'd3: master_level = LVL_REFRESH;
    endcase
  endfunction

  // Bus decode
  logic        acc;
  logic        wr;
  logic        hit_cfg;
  logic        hit_avr;
  logic        hit_rc;
  logic        mapped;
  logic        denied;
  assign acc = psel && penable;
  assign hit_cfg = paddr == OFS_CONFIG;
  assign hit_avr = paddr == OFS_AUTOVEC;
  assign hit_rc = paddr == OFS_RESET_CAUSE;
  assign mapped = hit_cfg || hit_avr || hit_rc;
  // Only configuration and autovector space is protected; cause record stays open
  assign denied = pwrite && module_configuration_q[PRIV_BIT]
                  && function_code != FC_SUP_DATA && (hit_cfg || hit_avr); // R12
  assign wr = acc && pwrite && !denied;
  assign pready = 1'b1;
  assign pslverr = acc && (!mapped || denied); // R12

  // Selector in force; slave mode pins it to split buses
  logic [1:0] show_sel;
  logic [1:0] show_read;
  assign show_read = slave_mode ? 2'b00 : module_configuration_q[SHOW_LSB +: 2]; // R10
  assign show_sel = show_read; // R10

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      module_configuration_q <= CONFIG_RESET; // R16
    end else if (wr && hit_cfg) begin
      module_configuration_q <= pwdata & CONFIG_WMASK;
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      autovector_enable_q <= AUTOVEC_RESET;
    end else if (wr && hit_avr) begin
      autovector_enable_q <= {pwdata[7:1], 1'b0};
    end
  end

  // Reset event collected at completion; set wins over clear
  logic [7:0] cause_set;
  logic [7:0] cause_clr;
  always_comb begin
    cause_set = 8'h00;
    if (reset_done) begin // R20
      cause_set[RC_HARD] = hard_reset_pin; // R22
      cause_set[RC_WDOG] = watchdog_reset; // R22
      cause_set[RC_DBF] = double_fault_reset; // R22
      cause_set[RC_LOC] = clock_loss_reset && clock_loss_reset_enable && vco_running; // R22
      cause_set[RC_SOFT] = soft_reset && !slave_mode; // R23
    end
  end
  assign cause_clr = (wr && hit_rc) ? (pwdata[7:0] & CAUSE_WMASK) : 8'h00; // R21

  // Only the power-up reset reloads the record, with the hard and power-up flags set
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      reset_cause_record_q <= CAUSE_POWERUP; // R20
    end else begin
      reset_cause_record_q <= (reset_cause_record_q & ~cause_clr) | cause_set; // R21
    end
  end

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata <= 32'h00000000;
    end else if (psel && !penable && !pwrite) begin
      unique case (1'b1)
        hit_cfg: prdata <= {module_configuration_q[31:10], show_read,
                            module_configuration_q[7:0]}; // R10
        hit_avr: prdata <= {24'h000000, autovector_enable_q};
        hit_rc:  prdata <= {24'h000000, reset_cause_record_q};
        default: prdata <= 32'h00000000;
      endcase
    end
  end

  // Arbitration by show mode
  logic arb_on;
  assign arb_on = show_sel != SHOW_NOARB; // R1 R2 R3
  assign ext_arb_enable = arb_on;
  logic req_seen;
  assign req_seen = arb_on && bus_request; // R6

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_grant_q <= 1'b0;
    end else if (!arb_on) begin
      bus_grant_q <= 1'b0; // R2
    end else if (req_seen && !bus_grant_acknowledge) begin
      bus_grant_q <= 1'b1;
    end else if (bus_grant_acknowledge || !bus_request) begin
      bus_grant_q <= 1'b0;
    end
  end
  assign bus_grant = bus_grant_q;

  // Halt holds until both request and acknowledge are gone
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      halt_q <= 1'b0;
    end else if (show_sel[1] && req_seen) begin
      halt_q <= 1'b1; // R7 R3
    end else if (!bus_request && !bus_grant_acknowledge) begin
      halt_q <= 1'b0; // R7
    end
  end
  assign internal_halt = halt_q || (show_sel[1] && req_seen); // R7

  // External pins for internal cycles; an outside master is assumed idle in mode 01
  logic showing;
  assign showing = internal_access && show_sel != SHOW_OFF; // R8
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ext_bus <= '0;
      reflect_addr_fc <= 1'b0;
    end else begin
      ext_bus.drive_addr <= showing; // R4
      ext_bus.drive_data <= showing; // R4 R5
      ext_bus.addr_strobe <= 1'b0; // R4 R5
      ext_bus.data_strobe <= showing; // R4 R5
      ext_bus.data_transfer_ack <= showing && !fast_termination; // R9
      reflect_addr_fc <= internal_access && (showing || ext_bus_free); // R11
    end
  end

  // Bus clear out from interrupt service level
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_clear_out <= 1'b0;
    end else begin
      bus_clear_out <= !slave_mode
                       && irq_service_level > module_configuration_q[MASK_LSB +: 3]; // R13
    end
  end

  // Bus clear in releases low-level masters; same field in slave mode
  always_comb begin
    for (int i = 0; i < 4; i++) begin
      master_release[i] = slave_mode && bus_clear_in && master_request[i]
                          && master_level(2'(i))
                             < module_configuration_q[MASK_LSB +: 3]; // R14 R15
    end
  end

  // Interrupt arbitration and autovector
  logic [3:0] iarb;
  assign iarb = module_configuration_q[IARB_LSB +: 4];
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      irq_arb_win <= 1'b0;
      autovector_ack <= 1'b0;
    end else begin
      irq_arb_win <= irq_ack_cycle && iarb > CPM_ARB_LEVEL
                     && iarb >= irq_source_level; // R16 R17
      autovector_ack <= irq_ack_cycle && autovector_enable_q[irq_ack_level]
                        && iarb != 4'h0; // R18 R19
    end
  end

  a_grant_never_01: assert property (@(posedge pclk) disable iff (!presetn)
    $past(show_sel) == SHOW_NOARB && show_sel == SHOW_NOARB |-> !bus_grant) // R2
    else $error("bus grant in mode 01");
  a_no_as_show: assert property (@(posedge pclk) disable iff (!presetn)
    !ext_bus.addr_strobe) // R4
    else $error("address strobe driven");
  a_off_no_data: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel == SHOW_OFF |=> !ext_bus.drive_data) // R5
    else $error("data driven with show off");
  a_fast_no_ack: assert property (@(posedge pclk) disable iff (!presetn)
    fast_termination |=> !ext_bus.data_transfer_ack) // R9
    else $error("transfer ack on fast cycle");
  a_halt_on_req: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel[1] && bus_request |-> internal_halt ##1 (halt_q || !bus_request)) // R7
    else $error("no halt on request");
  a_priv_err: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit_cfg && module_configuration_q[PRIV_BIT]
    && function_code != FC_SUP_DATA |=> $stable(module_configuration_q)) // R12
    else $error("user write changed config");
  a_bclr_out: assert property (@(posedge pclk) disable iff (!presetn)
    !slave_mode && irq_service_level > module_configuration_q[MASK_LSB +: 3]
    && $stable(module_configuration_q) |=> bus_clear_out) // R13
    else $error("bus clear out missing");
  a_autovector_ack_zero: assert property (@(posedge pclk) disable iff (!presetn)
    iarb == 4'h0 |=> !autovector_ack) // R19
    else $error("autovector with zero priority");
  a_cause_w1c: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_rc && pwdata[RC_POW] |=> !reset_cause_record_q[RC_POW]) // R21
    else $error("power flag not cleared");
  a_slave_sel: assert property (@(posedge pclk) disable iff (!presetn)
    slave_mode |-> show_sel == SHOW_OFF) // R10
    else $error("slave selector not 00");

  // Per-mode and per-flag checks; registered outputs are checked one edge later
  a_split_arb_on: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel == SHOW_OFF |-> ext_arb_enable) // R1
    else $error("arbitration off in mode 00");
  a_split_no_strobe: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel == SHOW_OFF |=> !ext_bus.data_strobe) // R1
    else $error("strobe driven in mode 00");
  a_noarb_off: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel == SHOW_NOARB |-> !ext_arb_enable) // R2
    else $error("arbitration on in mode 01");
  a_noarb_grant_clr: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel == SHOW_NOARB |=> !bus_grant) // R2
    else $error("grant after mode 01");
  a_show_arb_on: assert property (@(posedge pclk) disable iff (!presetn)
    show_sel[1] |-> ext_arb_enable) // R3
    else $error("arbitration off in mode 1x");
  a_grant_halts: assert property (@(posedge pclk) disable iff (!presetn)
    $past(show_sel[1]) && bus_grant |-> halt_q) // R3
    else $error("grant without halt in mode 1x");
  a_show_drive: assert property (@(posedge pclk) disable iff (!presetn)
    internal_access && show_sel != SHOW_OFF |=> ext_bus.drive_addr && ext_bus.drive_data
    && ext_bus.data_strobe) // R4
    else $error("show cycle not driven");
  a_idle_no_drive: assert property (@(posedge pclk) disable iff (!presetn)
    !showing |=> !ext_bus.data_strobe && !ext_bus.drive_data) // R5
    else $error("pins driven without show cycle");
  a_arb_off_ignore: assert property (@(posedge pclk) disable iff (!presetn)
    !arb_on |=> !bus_grant) // R6
    else $error("request seen with arbitration off");
  a_halt_release: assert property (@(posedge pclk) disable iff (!presetn)
    !bus_request && !bus_grant_acknowledge |=> !halt_q) // R7
    else $error("halt kept after release");
  a_halt_hold: assert property (@(posedge pclk) disable iff (!presetn)
    halt_q && bus_grant_acknowledge |=> halt_q) // R7
    else $error("halt dropped while acknowledged");
  a_ack_only_show: assert property (@(posedge pclk) disable iff (!presetn)
    !showing |=> !ext_bus.data_transfer_ack) // R9
    else $error("transfer ack without show cycle");
  a_slave_arb: assert property (@(posedge pclk) disable iff (!presetn)
    slave_mode |-> ext_arb_enable) // R10
    else $error("slave mode arbitration off");
  a_reflect_free: assert property (@(posedge pclk) disable iff (!presetn)
    internal_access && ext_bus_free |=> reflect_addr_fc) // R11
    else $error("free bus not reflecting");
  a_reflect_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !internal_access |=> !reflect_addr_fc) // R11
    else $error("reflect without access");
  a_priv_avr: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit_avr && module_configuration_q[PRIV_BIT]
    && function_code != FC_SUP_DATA |=> $stable(autovector_enable_q)) // R12
    else $error("user write changed autovector");
  a_priv_bus_error: assert property (@(posedge pclk) disable iff (!presetn)
    acc && pwrite && hit_cfg && module_configuration_q[PRIV_BIT]
    && function_code != FC_SUP_DATA |-> pslverr) // R12
    else $error("user write not refused");
  a_sup_write_ok: assert property (@(posedge pclk) disable iff (!presetn)
    acc && hit_avr && function_code == FC_SUP_DATA |-> !pslverr) // R12
    else $error("supervisor access refused");
  a_bclr_low: assert property (@(posedge pclk) disable iff (!presetn)
    irq_service_level <= module_configuration_q[MASK_LSB +: 3] |=> !bus_clear_out) // R13
    else $error("bus clear out at low level");
  a_bclr_slave: assert property (@(posedge pclk) disable iff (!presetn)
    slave_mode |=> !bus_clear_out) // R13
    else $error("bus clear out in slave mode");
  a_release_none: assert property (@(posedge pclk) disable iff (!presetn)
    !bus_clear_in |-> master_release == 4'h0) // R14
    else $error("release without bus clear in");
  a_release_normal: assert property (@(posedge pclk) disable iff (!presetn)
    !slave_mode |-> master_release == 4'h0) // R14
    else $error("release in normal mode");
  a_refresh_level: assert property (@(posedge pclk) disable iff (!presetn)
    master_release[3] |-> module_configuration_q[MASK_LSB +: 3] == 3'h7) // R15
    else $error("refresh released below level 7");
  a_serial_level: assert property (@(posedge pclk) disable iff (!presetn)
    master_release[0] |-> module_configuration_q[MASK_LSB +: 3] > 3'h4) // R15
    else $error("serial dma released at low level");
  a_iarb_low: assert property (@(posedge pclk) disable iff (!presetn)
    iarb <= CPM_ARB_LEVEL |=> !irq_arb_win) // R17
    else $error("win at or below processor level");
  a_no_ack_idle: assert property (@(posedge pclk) disable iff (!presetn)
    !irq_ack_cycle |=> !irq_arb_win && !autovector_ack) // R16
    else $error("response outside acknowledge");
  a_autovector_ack_off: assert property (@(posedge pclk) disable iff (!presetn)
    !autovector_enable_q[irq_ack_level] |=> !autovector_ack) // R18
    else $error("autovector on disabled level");
  a_autovector_ack_on: assert property (@(posedge pclk) disable iff (!presetn)
    irq_ack_cycle && autovector_enable_q[irq_ack_level] && iarb != 4'h0
    |=> autovector_ack) // R18
    else $error("autovector missing");
  a_cause_hold: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_done && !(wr && hit_rc) |=> $stable(reset_cause_record_q)) // R20
    else $error("cause record changed");
  a_cause_zero_wr: assert property (@(posedge pclk) disable iff (!presetn)
    wr && hit_rc && pwdata[7:0] == 8'h00 && !reset_done
    |=> $stable(reset_cause_record_q)) // R21
    else $error("zero write changed cause");
  a_cause_set_wins: assert property (@(posedge pclk) disable iff (!presetn)
    reset_done && hard_reset_pin |=> reset_cause_record_q[RC_HARD]) // R22
    else $error("hard reset not recorded");
  a_loc_gated: assert property (@(posedge pclk) disable iff (!presetn)
    !clock_loss_reset_enable && !reset_cause_record_q[RC_LOC]
    |=> !reset_cause_record_q[RC_LOC]) // R22
    else $error("clock loss recorded while disabled");
  a_soft_slave: assert property (@(posedge pclk) disable iff (!presetn)
    slave_mode && !reset_cause_record_q[RC_SOFT] |=> !reset_cause_record_q[RC_SOFT]) // R23
    else $error("soft reset recorded in slave mode");
  a_cause_resv: assert property (@(posedge pclk) disable iff (!presetn)
    !reset_cause_record_q[3] && !reset_cause_record_q[0]) // R22
    else $error("reserved cause bit set");

endmodule : bus_show_cycle_reset_status_cfg
`default_nettype wire

// file: test/far_master.sv
// Far-side bus master model: requests the bus, starts cycles only when granted
`timescale 1ns/1ns
`default_nettype none
module far_master (
  input  wire logic pclk,
  input  wire logic presetn,
  input  wire logic want,
  input  wire logic bus_grant,
  output logic      bus_request,
  output logic      bus_grant_acknowledge
);
  // Never takes the bus without a grant, so mode 01 sees no outside cycle
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bus_request           <= 1'b0;
      bus_grant_acknowledge <= 1'b0;
    end else begin
      bus_grant_acknowledge <= want && (bus_grant_acknowledge || bus_grant);
      bus_request           <= want && !bus_grant_acknowledge && !bus_grant;
    end
  end
endmodule // far_master
`default_nettype wire

// file: test/test_bus_show_cycle_reset_status_cfg.sv
// Self-checking bench: APB register access and sideband behaviour
`timescale 1ns/1ns
`default_nettype none
`define CHK(nm, e, g) begin n_tests++; if ((g) !== (e)) begin n_fail++; \
  $display("[ERR] %s expected %0h seen %0h", nm, e, g); end end
module test_bus_show_cycle_reset_status_cfg;
  import bsc_pkg::*;
  logic        pclk, presetn, psel, penable, pwrite, pready, pslverr, err, want;
  logic        slave_mode, internal_access, fast_termination, ext_bus_free, bus_request;
  logic        bus_grant_acknowledge, bus_grant, internal_halt, ext_arb_enable, reflect_addr_fc;
  logic        bus_clear_out, bus_clear_in, irq_ack_cycle, irq_arb_win, autovector_ack;
  logic        reset_done, hard_reset_pin, watchdog_reset, double_fault_reset, clock_loss_reset;
  logic        clock_loss_reset_enable, vco_running, soft_reset;
  logic [2:0]  irq_service_level, irq_ack_level;
  logic [3:0]  function_code, master_request, master_release, irq_source_level;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, rdat;
  ext_bus_s    ext_bus;
  int          n_fail = 0, n_tests = 0;
  logic [7:0]  rce [6] = '{8'h80, 8'h20, 8'h10, 8'h04, 8'h02, 8'h00};

  bus_show_cycle_reset_status_cfg uut (
    .pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .function_code, .pready,
    .prdata, .pslverr, .slave_mode, .internal_access, .fast_termination, .ext_bus_free,
    .bus_request, .bus_grant_acknowledge, .bus_grant, .internal_halt, .ext_arb_enable,
    .ext_bus, .reflect_addr_fc, .irq_service_level, .bus_clear_out, .bus_clear_in,
    .master_request, .master_release, .irq_ack_cycle, .irq_ack_level, .irq_source_level,
    .irq_arb_win, .autovector_ack, .reset_done, .hard_reset_pin, .watchdog_reset,
    .double_fault_reset, .clock_loss_reset, .clock_loss_reset_enable, .vco_running,
    .soft_reset
  );
  far_master partner (.pclk, .presetn, .want, .bus_grant, .bus_request, .bus_grant_acknowledge);

  always #2 pclk = ~pclk;

  function automatic logic [31:0] cfg(input logic [1:0] s, input logic p, input logic [2:0] k,
                                      input logic [3:0] ia);
    return (32'(s) << SHOW_LSB) | (32'(p) << PRIV_BIT) | (32'(k) << MASK_LSB) | 32'(ia);
  endfunction

  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                     input logic [3:0] fc);
    @(posedge pclk);
    {psel, pwrite, paddr, pwdata, function_code} <= {1'b1, w, a, d, fc};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rdat = prdata;
    err  = pslverr;
    {psel, penable} <= 2'b00;
  endtask
  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] fc,
                    input logic e);
    apb(1'b1, a, d, fc);
    `CHK("pslverr", e, err)
  endtask
  task automatic rd(input logic [11:0] a, input logic [31:0] x);
    apb(1'b0, a, 32'h0, FC_SUP_DATA);
    `CHK("prdata", x, rdat)
  endtask
  task automatic wt(input int n);
    repeat (n) @(negedge pclk);
  endtask
  task automatic report_and_stop();
    $display("comparisons %0d mismatches %0d", n_tests, n_fail);
    if (n_fail == 0 && n_tests > 0) begin
      $display("bench passed");
    end else begin
      $display("bench failed");
    end
    $finish;
  endtask

  initial begin
    repeat (5000) @(posedge pclk);
    n_fail++;
    report_and_stop();
  end

  initial begin
    {pclk, presetn, psel, penable, pwrite, paddr, pwdata, function_code, slave_mode, want,
     internal_access, fast_termination, ext_bus_free, irq_service_level, bus_clear_in,
     master_request, irq_ack_cycle, irq_ack_level, irq_source_level, reset_done,
     hard_reset_pin, watchdog_reset, double_fault_reset, clock_loss_reset,
     clock_loss_reset_enable, vco_running, soft_reset} = '0;
    repeat (6) @(posedge pclk);
    presetn <= 1'b1;
    rd(OFS_CONFIG, CONFIG_RESET);
    rd(OFS_AUTOVEC, 32'h0);
    rd(OFS_RESET_CAUSE, {24'h0, CAUSE_POWERUP});
    wr(OFS_RESET_CAUSE, 32'h0, FC_SUP_DATA, 1'b0);
    rd(OFS_RESET_CAUSE, 32'hC0);
    wr(OFS_RESET_CAUSE, 32'h40, 4'h1, 1'b0);
    rd(OFS_RESET_CAUSE, 32'h80);
    vco_running <= 1'b1;
    // Last pass raises clock loss with its enable off: nothing may be recorded
    for (int i = 0; i < 6; i++) begin
      wr(OFS_RESET_CAUSE, 32'hFF, FC_SUP_DATA, 1'b0);
      {hard_reset_pin, watchdog_reset, double_fault_reset, clock_loss_reset, soft_reset,
       reset_done, clock_loss_reset_enable} <= {5'h10 >> (i == 5 ? 3 : i), 1'b1, i < 5};
      @(posedge pclk);
      reset_done <= 1'b0;
      rd(OFS_RESET_CAUSE, {24'h0, rce[i]});
    end
    {hard_reset_pin, watchdog_reset, double_fault_reset, clock_loss_reset, soft_reset} <= '0;
    wr(OFS_CONFIG, cfg(2'h0, 1'b1, 3'h3, 4'hF), FC_SUP_DATA, 1'b0);
    wr(OFS_AUTOVEC, 32'h8, 4'h1, 1'b1);
    rd(OFS_AUTOVEC, 32'h0);
    wr(OFS_AUTOVEC, 32'h8, FC_SUP_DATA, 1'b0);
    rd(OFS_AUTOVEC, 32'h8);
    apb(1'b0, 12'h00C, 32'h0, FC_SUP_DATA);
    `CHK("unmapped", 1'b1, err)
    {internal_access, fast_termination} <= 2'b11;
    for (int m = 0; m < 4; m++) begin
      wr(OFS_CONFIG, cfg(2'(m), 1'b0, 3'h3, 4'hF), FC_SUP_DATA, 1'b0);
      wt(2);
      `CHK("ext_bus", ext_bus_s'({m != 0, m != 0, 1'b0, m != 0, 1'b0}), ext_bus)
      `CHK("arb_en", m != 1, ext_arb_enable)
      @(posedge pclk);
      want <= 1'b1;
      wt(4);
      `CHK("bus_ack", m != 1, bus_grant_acknowledge)
      `CHK("halt", m > 1, internal_halt)
      @(posedge pclk);
      want <= 1'b0;
      wt(3);
      `CHK("halt", 1'b0, internal_halt)
    end
    wr(OFS_CONFIG, cfg(2'h0, 1'b0, 3'h3, 4'hF), FC_SUP_DATA, 1'b0);
    {ext_bus_free, irq_service_level} <= {1'b1, 3'h4};
    wt(2);
    `CHK("reflect", 1'b1, reflect_addr_fc)
    `CHK("bclr_out", 1'b1, bus_clear_out)
    @(posedge pclk);
    {irq_service_level, irq_ack_cycle, irq_ack_level, irq_source_level} <= {7'h3B, CPM_ARB_LEVEL};
    wt(2);
    `CHK("bclr_out", 1'b0, bus_clear_out)
    `CHK("autovector_ack", 1'b1, autovector_ack)
    `CHK("arb_win", 1'b1, irq_arb_win)
    @(posedge pclk);
    irq_ack_level <= 3'h2;
    wt(2);
    `CHK("autovector_ack", 1'b0, autovector_ack)
    wr(OFS_CONFIG, cfg(2'h0, 1'b0, 3'h3, 4'h1), FC_SUP_DATA, 1'b0);
    irq_ack_level <= 3'h3;
    wt(2);
    `CHK("arb_win", 1'b0, irq_arb_win)
    wr(OFS_CONFIG, cfg(2'h0, 1'b0, 3'h3, 4'h0), FC_SUP_DATA, 1'b0);
    wt(2);
    `CHK("autovector_ack", 1'b0, autovector_ack)
    {irq_ack_cycle, slave_mode, master_request, bus_clear_in} <= {1'b0, 1'b1, 4'hF, 1'b1};
    wr(OFS_CONFIG, cfg(2'h1, 1'b0, 3'h3, 4'hF), FC_SUP_DATA, 1'b0);
    rd(OFS_CONFIG, cfg(2'h0, 1'b0, 3'h3, 4'hF));
    `CHK("arb_en", 1'b1, ext_arb_enable)
    `CHK("release", 4'h6, master_release)
    bus_clear_in <= 1'b0;
    wt(2);
    `CHK("release", 4'h0, master_release)
    report_and_stop();
  end
endmodule // test_bus_show_cycle_reset_status_cfg
`default_nettype wire
